// ### usart_core.sv
// serial transceiver: fifos, framing, infrared, flow control, registers
// assumes pins synchronous to ref_clk and a master that never waits
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "usart_consts.svh"

module usart_core
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire usart_pkg::bus_req_s bus,
    output logic [31:0]             rd_data,
    input  wire logic               rx_in,
    input  wire logic               cts_n,
    output logic                    tx_out,
    output logic                    sclk,
    output logic                    rts_n,
    output logic                    de,
    output logic                    irq
);

    usart_pkg::state_s st_r;
    usart_pkg::state_s st_nxt;

    logic        tick;
    logic        sync;
    logic [3:0]  nb;
    logic [3:0]  tpbm;
    logic [3:0]  half;
    logic [3:0]  need;
    logic        line;
    logic [6:0]  set;
    logic [6:0]  clr;
    logic [8:0]  rxd;
    logic [8:0]  txd;
    logic        pop_rx;

    // ************************************
    // helpers
    // ************************************
    function automatic logic [8:0] order(input logic [8:0] d,
                                         input logic [3:0] n,
                                         input logic       msb);
        logic [8:0] o;
        o = 9'h000;
        for (int i = 0; i < 9; i++)
            if (i < n)
                o[i] = msb ? d[n - 4'(i) - 4'd1] : d[i];
        return o;
    endfunction : order

    function automatic logic [12:0] frame(input logic [8:0]  d,
                                          input logic [3:0]  n,
                                          input logic [15:0] c);
        logic [12:0] f;
        f = 13'h1FFF;
        f[0] = 1'b0;
        for (int i = 0; i < 9; i++)
            if (i < n)
                f[i + 1] = d[i];
        if (c[`CTL_PAREN])
            f[n + 4'd1] = (^d) ^ c[`CTL_PARODD];
        return f;
    endfunction : frame

    // ************************************
    // next state
    // ************************************
    always_comb
    begin
        st_nxt = st_r;
        set = 7'h00;
        clr = 7'h00;
        pop_rx = 1'b0;
        sync = st_r.ctrl[`CTL_SYNC];
        tpbm = sync ? `TPB_SYNC : `TPB_ASYNC;
        half = sync ? `HALF_SYNC : `HALF_ASYNC;
        nb = 4'd7 + {2'b00, st_r.ctrl[`CTL_WLEN +: 2]};
        if (nb > 4'd9)
            nb = 4'd9;
        need = nb + {3'b000, st_r.ctrl[`CTL_PAREN]} + 4'd1;
        tick = (st_r.bcnt == st_r.baud);
        st_nxt.bcnt = tick ? 16'h0000 : st_r.bcnt + 16'h0001;
        line = st_r.ctrl[`CTL_IRDA] ? (st_r.irst == 5'd0) : rx_in;
        txd = order(st_r.txm[st_r.txr], nb, st_r.ctrl[`CTL_MSBF]);
        rxd = order(st_r.rxsh[8:0], nb, st_r.ctrl[`CTL_MSBF]);

        // register port
        st_nxt.rdata = 32'h0000_0000;
        if (bus.wr)
        begin
            if (bus.addr == `OFS_DATA)
            begin
                if (st_r.txc != `FIFO_DEPTH)
                begin
                    st_nxt.txm[st_r.txw] = bus.wdata[8:0];
                    st_nxt.txw = st_r.txw + 3'd1;
                    st_nxt.txc = st_nxt.txc + 4'd1;
                end
            end
            else if (bus.addr == `OFS_CTRL)
                st_nxt.ctrl = bus.wdata[15:0];
            else if (bus.addr == `OFS_STAT)
                clr = bus.wdata[6:0];
            else if (bus.addr == `OFS_MASK)
                st_nxt.mask = bus.wdata[6:0];
            else if (bus.addr == `OFS_BAUD)
                st_nxt.baud = bus.wdata[15:0];
        end
        if (bus.rd)
        begin
            if (bus.addr == `OFS_DATA)
            begin
                st_nxt.rdata = {23'h00_0000, st_r.rxm[st_r.rxr]};
                pop_rx = (st_r.rxc != 4'd0);
            end
            else if (bus.addr == `OFS_CTRL)
                st_nxt.rdata = {16'h0000, st_r.ctrl};
            else if (bus.addr == `OFS_STAT)
                st_nxt.rdata = {14'h0000, st_r.rxst != usart_pkg::RX_IDLE,
                                st_r.txst == usart_pkg::TX_RUN,
                                st_r.rxc, st_r.txc, 1'b0, st_r.stat};
            else if (bus.addr == `OFS_MASK)
                st_nxt.rdata = {25'h000_0000, st_r.mask};
            else if (bus.addr == `OFS_BAUD)
                st_nxt.rdata = {16'h0000, st_r.baud};
        end
        if (pop_rx)
        begin
            st_nxt.rxr = st_r.rxr + 3'd1;
            st_nxt.rxc = st_nxt.rxc - 4'd1;
        end

        // transmitter
        case (st_r.txst)
            usart_pkg::TX_IDLE:
            begin
                if (st_r.ctrl[`CTL_TXEN] && st_r.txc != 4'd0 &&
                    (!st_r.ctrl[`CTL_HWFC] || !cts_n))
                begin
                    st_nxt.txsh = frame(txd, nb, st_r.ctrl);
                    st_nxt.txn = need + {3'b000, st_r.ctrl[`CTL_STOP2]} +
                                 4'd1;
                    st_nxt.txt = 4'd0;
                    st_nxt.txst = usart_pkg::TX_RUN;
                    st_nxt.txr = st_r.txr + 3'd1;
                    st_nxt.txc = st_nxt.txc - 4'd1;
                    if (st_nxt.txc == 4'd0)
                        set[`ST_TXE] = 1'b1;
                end
            end
            usart_pkg::TX_RUN:
            begin
                if (tick)
                begin
                    if (st_r.txt == tpbm)
                    begin
                        st_nxt.txt = 4'd0;
                        st_nxt.txsh = {1'b1, st_r.txsh[12:1]};
                        st_nxt.txn = st_r.txn - 4'd1;
                        if (st_r.txn == 4'd1)
                            st_nxt.txst = usart_pkg::TX_IDLE;
                    end
                    else
                        st_nxt.txt = st_r.txt + 4'd1;
                end
            end
            default:
                st_nxt.txst = usart_pkg::TX_IDLE;
        endcase

        // infrared pulse stretch
        // load only in infrared mode, else idle high fakes a start bit
        if (st_r.ctrl[`CTL_IRDA] && rx_in)
            st_nxt.irst = `IR_HOLD;
        else if (tick && st_r.irst != 5'd0)
            st_nxt.irst = st_r.irst - 5'd1;

        // receiver
        case (st_r.rxst)
            usart_pkg::RX_IDLE:
            begin
                if (st_r.ctrl[`CTL_RXEN] && !line)
                begin
                    st_nxt.rxst = usart_pkg::RX_START;
                    st_nxt.rxt = 4'd0;
                    st_nxt.rxn = 4'd0;
                    st_nxt.rxsh = 12'h000;
                end
            end
            usart_pkg::RX_START:
            begin
                if (tick)
                begin
                    st_nxt.rxt = st_r.rxt + 4'd1;
                    if (st_r.rxt == half)
                    begin
                        st_nxt.rxt = 4'd0;
                        st_nxt.rxst = line ? usart_pkg::RX_IDLE :
                                             usart_pkg::RX_DATA;
                    end
                end
            end
            usart_pkg::RX_DATA:
            begin
                if (tick)
                begin
                    st_nxt.rxt = st_r.rxt + 4'd1;
                    if (st_r.rxt == tpbm)
                    begin
                        st_nxt.rxt = 4'd0;
                        st_nxt.rxsh[st_r.rxn] = line;
                        st_nxt.rxn = st_r.rxn + 4'd1;
                        if (st_r.rxn == need - 4'd1)
                        begin
                            st_nxt.rxst = usart_pkg::RX_IDLE;
                            set[`ST_FE] = !line;
                            set[`ST_BRK] = !line && st_r.rxsh == 12'h000;
                            set[`ST_PE] = st_r.ctrl[`CTL_PAREN] &&
                                          ((^rxd) ^ st_r.ctrl[`CTL_PARODD]
                                           ^ st_r.rxsh[nb]);
                            if (st_nxt.rxc == `FIFO_DEPTH)
                                set[`ST_OE] = 1'b1;
                            else
                            begin
                                st_nxt.rxm[st_r.rxw] = rxd;
                                st_nxt.rxw = st_r.rxw + 3'd1;
                                st_nxt.rxc = st_nxt.rxc + 4'd1;
                                if (st_nxt.rxc ==
                                    {1'b0, st_r.ctrl[`CTL_THR +: 3]} + 4'd1)
                                    set[`ST_RXT] = 1'b1;
                            end
                        end
                    end
                end
            end
            default:
                st_nxt.rxst = usart_pkg::RX_IDLE;
        endcase

        // receive timeout
        if (st_r.rxc == 4'd0 || st_r.rxst != usart_pkg::RX_IDLE || pop_rx)
            st_nxt.tocnt = 10'd0;
        else if (tick && st_r.tocnt != `TOUT_TICKS)
        begin
            st_nxt.tocnt = st_r.tocnt + 10'd1;
            if (st_nxt.tocnt == `TOUT_TICKS)
                set[`ST_TOUT] = 1'b1;
        end

        // sticky flags: a new event beats a clear
        st_nxt.stat = (st_r.stat & ~clr) | set;
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

        // pins
        if (st_nxt.ctrl[`CTL_IRDA])
            st_nxt.tx_out = st_nxt.txst == usart_pkg::TX_RUN &&
                            !st_nxt.txsh[0] && st_nxt.txt < `IR_PULSE;
        else
            st_nxt.tx_out = st_nxt.txst == usart_pkg::TX_IDLE ||
                            st_nxt.txsh[0];
        st_nxt.sclk = st_nxt.ctrl[`CTL_SYNC] &&
                      st_nxt.txst == usart_pkg::TX_RUN &&
                      st_nxt.txt > half;
        st_nxt.de = st_nxt.ctrl[`CTL_RS485] &&
                    st_nxt.txst == usart_pkg::TX_RUN;
        st_nxt.rts_n = st_nxt.ctrl[`CTL_HWFC] &&
                       st_nxt.rxc >= `RTS_LIMIT;
    end

    // ************************************
    // state register
    // ************************************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.ctrl <= `CTRL_RST;
            st_r.baud <= `BAUD_RST;
            st_r.tx_out <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign rd_data = st_r.rdata;
    assign tx_out = st_r.tx_out;
    assign sclk = st_r.sclk;
    assign rts_n = st_r.rts_n;
    assign de = st_r.de;
    assign irq = st_r.irq;

endmodule : usart_core

// ### usart_consts.svh
// register offsets, field positions, reset values and timing counts
// assumes a byte-addressed register port with 32-bit data
`ifndef USART_CONSTS_SVH
`define USART_CONSTS_SVH

// ************************************
// register offsets
// ************************************
`define OFS_DATA   8'h00
`define OFS_CTRL   8'h04
`define OFS_STAT   8'h08
`define OFS_MASK   8'h0C
`define OFS_BAUD   8'h10

// ************************************
// control fields
// ************************************
`define CTL_TXEN   0
`define CTL_RXEN   1
`define CTL_SYNC   2
`define CTL_WLEN   3
`define CTL_PAREN  5
`define CTL_PARODD 6
`define CTL_STOP2  7
`define CTL_MSBF   8
`define CTL_HWFC   9
`define CTL_IRDA   10
`define CTL_RS485  11
`define CTL_THR    12
`define CTRL_RST   16'h0008
`define BAUD_RST   16'h0000

// ************************************
// status and mask bits
// ************************************
`define ST_PE      0
`define ST_FE      1
`define ST_OE      2
`define ST_BRK     3
`define ST_TXE     4
`define ST_RXT     5
`define ST_TOUT    6

// ************************************
// timing
// ************************************
`define FIFO_DEPTH 4'd8
`define TPB_ASYNC  4'd15
`define TPB_SYNC   4'd7
`define HALF_ASYNC 4'd7
`define HALF_SYNC  4'd3
`define IR_PULSE   4'd3
`define IR_HOLD    5'd16
`define TOUT_TICKS 10'd640
`define RTS_LIMIT  4'd7

`endif

// ### usart_pkg.sv
// types shared by the serial transceiver
// assumes usart_consts.svh for the numbers
package usart_pkg;

    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_RUN = 1'b1} tx_state_e;
    typedef enum logic [1:0]
    {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10
    } rx_state_e;

    typedef struct packed
    {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_s;

    typedef struct packed
    {
        logic [15:0]      ctrl;
        logic [15:0]      baud;
        logic [6:0]       stat;
        logic [6:0]       mask;
        logic [31:0]      rdata;
        logic [15:0]      bcnt;
        logic [7:0][8:0]  txm;
        logic [2:0]       txw;
        logic [2:0]       txr;
        logic [3:0]       txc;
        logic [7:0][8:0]  rxm;
        logic [2:0]       rxw;
        logic [2:0]       rxr;
        logic [3:0]       rxc;
        tx_state_e        txst;
        logic [12:0]      txsh;
        logic [3:0]       txn;
        logic [3:0]       txt;
        rx_state_e        rxst;
        logic [11:0]      rxsh;
        logic [3:0]       rxn;
        logic [3:0]       rxt;
        logic [4:0]       irst;
        logic [9:0]       tocnt;
        logic             tx_out;
        logic             sclk;
        logic             de;
        logic             rts_n;
        logic             irq;
    } state_s;

endpackage : usart_pkg

// ### remote_dev.sv
// remote serial device model: echoes the line back, drives clear-to-send
// assumes the same clock as the transceiver
`timescale 1ns/10ps

module remote_dev
(
    input  wire logic ref_clk,
    input  wire logic line_in,
    input  wire logic pause,
    input  wire logic hold_low,
    output logic      line_out,
    output logic      cts_n
);
    initial line_out = 1'b1;

    // ****************
    // echo path
    // ****************
    always @(posedge ref_clk)
        line_out <= hold_low ? 1'b0 : line_in;
    assign cts_n = pause;
endmodule : remote_dev

// ### usart_chk.sv
// port checker for the serial transceiver
// assumes baud divisor 0 while lines are active
`timescale 1ns/10ps
`include "usart_consts.svh"

module usart_chk
(
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire usart_pkg::bus_req_s bus,
    input wire logic [31:0]         rd_data,
    input wire logic                rx_in,
    input wire logic                cts_n,
    input wire logic                tx_out,
    input wire logic                sclk,
    input wire logic                rts_n,
    input wire logic                de,
    input wire logic                irq
);
    logic [3:0] on_r;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // ****************
    // shadow of mask, flow, sync and infrared bits
    // ****************
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            on_r <= 4'h0;
        else if (bus.wr && bus.addr == `OFS_MASK)
            on_r[0] <= |bus.wdata[6:0];
        else if (bus.wr && bus.addr == `OFS_CTRL)
            on_r[3:1] <= {bus.wdata[`CTL_IRDA], bus.wdata[`CTL_SYNC],
                          bus.wdata[`CTL_HWFC]};
    end

    // ****************
    // assertions
    // ****************
    chk_rd_quiet: assert property (!$past(bus.rd) |-> rd_data == 32'h0)
        else $error("read data outside read slot");
    chk_rd_unmapped: assert property (bus.rd && !(bus.addr inside
        {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}) |=> rd_data == 32'h0)
        else $error("unmapped read not zero");
    chk_irq_masked: assert property (!on_r[0] && !$past(on_r[0]) |-> !irq)
        else $error("interrupt with empty mask");
    chk_rts_flow: assert property (!on_r[1] && !$past(on_r[1]) |-> !rts_n)
        else $error("rts raised without flow control");
    chk_sclk_sync: assert property (!on_r[2] && !$past(on_r[2]) |-> !sclk)
        else $error("clock out in async mode");
    chk_start_width: assert property ($fell(tx_out) && !on_r[3]
        |-> !tx_out [*8])
        else $error("low bit too short");
    chk_sclk_width: assert property ($rose(sclk) |-> sclk [*4])
        else $error("sync clock high too short");
    chk_de_start: assert property ($rose(de) |-> ##[0:1] !tx_out)
        else $error("driver enable without start bit");
    chk_de_stop: assert property ($fell(de) |-> tx_out)
        else $error("driver off before stop bit");
endmodule : usart_chk

bind usart_core usart_chk chk_i
(
    .ref_clk (ref_clk),
    .rst     (rst),
    .bus     (bus),
    .rd_data (rd_data),
    .rx_in   (rx_in),
    .cts_n   (cts_n),
    .tx_out  (tx_out),
    .sclk    (sclk),
    .rts_n   (rts_n),
    .de      (de),
    .irq     (irq)
);

// ### tb.sv
// testbench: frame table through a loopback partner, then edge cases
// assumes usart_core, remote_dev and the bound checker
`timescale 1ns/10ps
`include "usart_consts.svh"

module tb;
    typedef struct packed
    {
        logic [15:0] c;
        logic [8:0]  d;
        logic [8:0]  e;
        logic        w;
    } row_s;

    logic                ref_clk = 1'b0;
    logic                rst     = 1'b1;
    usart_pkg::bus_req_s bus     = '0;
    logic [31:0]         rd_data;
    logic                rx_in;
    logic                cts_n;
    logic                tx_out;
    logic                sclk;
    logic                rts_n;
    logic                de;
    logic                irq;
    logic                pause   = 1'b0;
    logic                brk     = 1'b0;
    logic [31:0]         v;
    logic [9:0]          f;
    logic [9:0]          ef;
    int                  fails   = 0;
    int                  samples_checked = 0;
    int                  cyc     = 0;
    row_s                rows [11] = '{
        '{16'h000B, 9'h0A5, 9'h0A5, 1'b1},
        '{16'h010B, 9'h02D, 9'h02D, 1'b1},
        '{16'h080B, 9'h071, 9'h071, 1'b1},
        '{16'h0003, 9'h1FF, 9'h07F, 1'b0},
        '{16'h0013, 9'h1A5, 9'h1A5, 1'b0},
        '{16'h002B, 9'h0C3, 9'h0C3, 1'b0},
        '{16'h00EB, 9'h03C, 9'h03C, 1'b0},
        '{16'h0133, 9'h155, 9'h155, 1'b0},
        '{16'h020B, 9'h018, 9'h018, 1'b0},
        '{16'h000F, 9'h05A, 9'h05A, 1'b0},
        '{16'h040B, 9'h096, 9'h096, 1'b0}};

    usart_core uut
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .bus     (bus),
        .rd_data (rd_data),
        .rx_in   (rx_in),
        .cts_n   (cts_n),
        .tx_out  (tx_out),
        .sclk    (sclk),
        .rts_n   (rts_n),
        .de      (de),
        .irq     (irq)
    );

    remote_dev far
    (
        .ref_clk  (ref_clk),
        .line_in  (tx_out),
        .pause    (pause),
        .hold_low (brk),
        .line_out (rx_in),
        .cts_n    (cts_n)
    );

    // ****************
    // clock, timeout, tasks
    // ****************
    initial forever #2.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 30000)
        begin
            fails = fails + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1;
        v = rd_data;
    endtask : rd

    task automatic wait_rx(input int n);
        v = 32'h0000_0000;
        for (int i = 0; i < 1000 && v[15:12] < n; i++)
            rd(`OFS_STAT);
    endtask : wait_rx

    task automatic grab();
        @(negedge tx_out);
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < 10; i++)
        begin
            f[i] = tx_out;
            repeat (16) @(posedge ref_clk);
        end
    endtask : grab

    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : settle

    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`OFS_CTRL);
        chk("ctrl", 32'h0000_0008, v);
        rd(`OFS_STAT);
        chk("stat", 32'h0000_0000, v);
        rd(8'h20);
        chk("unmapped", 32'h0000_0000, v);
        for (int r = 0; r < 11; r++)
        begin
            wr(`OFS_CTRL, {16'h0000, rows[r].c});
            wr(`OFS_DATA, {23'h0, rows[r].d});
            if (rows[r].w)
            begin
                grab();
                ef = 10'h200;
                for (int i = 0; i < 8; i++)
                    ef[i + 1] = rows[r].c[`CTL_MSBF] ? rows[r].d[7 - i]
                                                    : rows[r].d[i];
                chk("frame", ef, f);
            end
            wait_rx(1);
            rd(`OFS_DATA);
            chk("char", rows[r].e, v);
            rd(`OFS_STAT);
            chk("errors", 32'h0000_0000, v[3:0]);
            wr(`OFS_STAT, 32'h0000_007F);
        end
        wr(`OFS_CTRL, 32'h0000_000B);
        wr(`OFS_MASK, 32'h0000_0010);
        wr(`OFS_DATA, 32'h0000_0033);
        wait_rx(1);
        rd(`OFS_DATA);
        chk("irq set", 32'h0000_0001, irq);
        wr(`OFS_MASK, 32'h0000_0000);
        settle();
        chk("irq masked", 32'h0000_0000, irq);
        wr(`OFS_MASK, 32'h0000_0010);
        settle();
        chk("irq unmasked", 32'h0000_0001, irq);
        wr(`OFS_STAT, 32'h0000_0010);
        settle();
        chk("irq cleared", 32'h0000_0000, irq);
        wr(`OFS_CTRL, 32'h0000_020A);
        for (int i = 0; i < 9; i++)
            wr(`OFS_DATA, i);
        rd(`OFS_STAT);
        chk("tx count", 32'h0000_0008, v[11:8]);
        wr(`OFS_CTRL, 32'h0000_020B);
        wait_rx(8);
        repeat (200) @(posedge ref_clk);
        chk("rts", 32'h0000_0001, rts_n);
        pause <= 1'b1;
        wr(`OFS_DATA, 32'h0000_0009);
        repeat (100) @(posedge ref_clk);
        rd(`OFS_STAT);
        chk("tx held", 32'h0000_0001, v[11:8]);
        pause <= 1'b0;
        repeat (900) @(posedge ref_clk);
        rd(`OFS_STAT);
        chk("rx count", 32'h0000_0008, v[15:12]);
        chk("sticky", 32'h0000_0074, v[6:0]);
        for (int i = 0; i < 8; i++)
        begin
            rd(`OFS_DATA);
            chk("fifo data", i, v);
        end
        wr(`OFS_STAT, 32'h0000_007F);
        brk <= 1'b1;
        repeat (400) @(posedge ref_clk);
        brk <= 1'b0;
        repeat (100) @(posedge ref_clk);
        rd(`OFS_STAT);
        chk("break", 32'h0000_000A, v[3:0]);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`OFS_CTRL);
        chk("ctrl again", 32'h0000_0008, v);
        print_verdict();
    end
endmodule : tb
